// *** verilog/external_bus_pin_mux.sv ***
// Pin function multiplexer for ports zero to four and port ten
// Function
// - Bus width pin low gives a 16-bit data bus, high gives 8 bits.
// - With the width pin low, each of chip select areas 1-3 may narrow to 8.
// - Single-chip: port zero is 8 general I/O pins, per-pin direction bits.
// - Reset clears direction bits so every general I/O pin starts as input.
// - Expansion modes: port zero drives A16-A23, per-pin return to I/O.
// - Expansion modes: port one carries data bits 0-7 both ways.
// - 8-bit bus plus select: port one sends low address, then data.
// - Port two carries data 8-15 only while the width pin is low, else general I/O.
// - Expansion: port three bit 0 stays I/O; bits 1-3 read, low, high strobes.
// - Expansion: a select makes port three bit 0 drive ready out.
// - Microprocessor: port three bit 0 takes ready in unless set to I/O.
// - A high width pin frees the high byte write strobe pin for I/O; area narrowing does not.
// - Expansion: port four defaults I/O, each pin switchable to its bus role.
// - Microprocessor: port four bits 0-4 default to bus roles, 5-7 to I/O.
// - Microprocessor: bits 0-3 may revert to I/O, bits 5-7 become selects 1-3.
// - Expansion modes: port ten drives address bits 0-7.
`timescale 1ns/10ps
`default_nettype none
`include "external_bus_pin_mux_params.svh"

module external_bus_pin_mux (
   input  wire logic                         core_clk,
   input  wire logic                         reset_n,
   input  wire logic                         proc_mode_pin,
   input  wire logic                         expand_sel,
   input  wire logic                         bus_width_pin,
   input  wire logic [2:0]                   area_narrow,
   input  wire logic [7:0]                   p0_gpio_sel,
   input  wire logic                         p1_mux_en,
   input  wire logic                         p30_rdy_out_en,
   input  wire logic                         p30_gpio_sel,
   input  wire logic [7:0]                   p4_func_en,
   input  wire logic [3:0]                   p4_gpio_sel,
   input  wire logic [2:0]                   p4_cs_en,
   input  wire logic [5:0]                   dir_we,
   input  wire logic [5:0]                   data_we,
   input  wire logic [7:0]                   wr_data,
   input  wire pin_mux_pkg::bus_ctrl_s       bus,
   input  wire logic [5:0][7:0]              pins_in,
   output pin_mux_pkg::port_pins_s [5:0]     pins,
   output pin_mux_pkg::bus_resp_s            bus_resp,
   output logic [5:0][7:0]                   port_rd,
   output logic                              wide_bus
);
   import pin_mux_pkg::*;

   mode_e            mode;
   logic             ext;
   logic             expand;
   logic             micro;
   logic             narrow_now;
   logic             muxed;
   logic [3:0]       p3_on;
   logic [7:0]       p4_on;
   logic [5:0][7:0]  dir;
   logic [5:0][7:0]  dout;
   logic [5:0][7:0]  fsel;
   logic [5:0][7:0]  fout;
   logic [5:0][7:0]  foe_n;
   port_pins_s [5:0] pins_r;
   port_pins_s [5:0] pins_nxt;
   bus_resp_s        resp_r;
   bus_resp_s        resp_nxt;

   // Mode pin high is microprocessor; low leaves the software select to decide
   always_comb begin
      if (proc_mode_pin) begin
         mode = MODE_MICRO;
      end else if (expand_sel) begin
         mode = MODE_EXPAND;
      end else begin
         mode = MODE_SINGLE;
      end
   end

   assign ext    = (mode != MODE_SINGLE);
   assign expand = (mode == MODE_EXPAND);
   assign micro  = (mode == MODE_MICRO);

   // Area narrowing only counts while the width pin asks for 16 bits
   assign narrow_now = bus_width_pin | (|(area_narrow & ~bus.chip_select_lines_n[3:1]));
   assign wide_bus   = ext & ~narrow_now;
   assign muxed      = ext & narrow_now & p1_mux_en;

   // One latch and direction set per port, port ten included
   for (genvar g = 0; g < `PORT_COUNT; g++) begin : g_port
      gpio_port #(
         .W (8)
      ) u_port (
         .core_clk (core_clk),
         .reset_n  (reset_n),
         .dir_we   (dir_we[g]),
         .data_we  (data_we[g]),
         .wr_data  (wr_data),
         .pin_in   (pins_in[g]),
         .dir      (dir[g]),
         .dout     (dout[g]),
         .rd_data  (port_rd[g])
      );
   end

   // Port three bit 0: ready out in expansion, ready in for the processor
   always_comb begin
      p3_on[`P3_RDY_BIT] = expand ? p30_rdy_out_en : (micro & ~p30_gpio_sel);
      p3_on[`P3_RD_BIT]  = ext;
      p3_on[`P3_BLW_BIT] = ext;
      p3_on[`P3_BHW_BIT] = ext & ~bus_width_pin;
   end

   // Port four roles: opt-in in expansion; for the processor bits 0-3 opt-out, bit 4 fixed, bits 5-7 opt-in
   always_comb begin
      if (expand) begin
         p4_on = p4_func_en;
      end else if (micro) begin
         p4_on = {p4_cs_en, 1'b1, ~p4_gpio_sel};
      end else begin
         p4_on = 8'h00;
      end
   end

   // Bus function level and drive for every pin that has one
   always_comb begin
      fsel  = '0;
      fout  = '0;
      foe_n = '1;
      for (int i = 0; i < 8; i++) begin
         fsel[0][i]  = ext & ~p0_gpio_sel[i];
         fout[0][i]  = bus.addr[`ADDR_HI_LSB + i];
         foe_n[0][i] = 1'b0;
         fsel[1][i]  = ext;
         fout[1][i]  = (muxed & bus.addr_phase) ? bus.addr[i] : bus.wdata[i];
         foe_n[1][i] = ~((muxed & bus.addr_phase) | bus.data_oe);
         fsel[2][i]  = ext & ~bus_width_pin;
         fout[2][i]  = bus.wdata[8 + i];
         foe_n[2][i] = ~bus.data_oe;
         fsel[`PORT_TEN_IDX][i]  = ext;
         fout[`PORT_TEN_IDX][i]  = bus.addr[i];
         foe_n[`PORT_TEN_IDX][i] = 1'b0;
      end
      fsel[3][3:0] = p3_on;
      fout[3][3:0] = {bus.high_byte_write_strobe_n, bus.low_byte_write_strobe_n,
                      bus.rd_strobe_n, bus.rdy_out};
      // Ready is an input for the processor, so it is never driven there
      foe_n[3][3:0] = {3'b000, ~expand};
      fsel[4]  = p4_on;
      fout[4]  = {bus.chip_select_lines_n, 1'b1, bus.hold_acknowledge_n, bus.bus_clk, bus.ale};
      foe_n[4] = `P4_FUNC_OE_N;
   end

   // Single select per pin: bus role wins, else latch and direction
   always_comb begin
      for (int p = 0; p < `PORT_COUNT; p++) begin
         pins_nxt[p].out  = (fsel[p] & fout[p]) | (~fsel[p] & dout[p]);
         pins_nxt[p].oe_n = (fsel[p] & foe_n[p]) | (~fsel[p] & ~dir[p]);
      end
      // Port three has four pads only
      pins_nxt[3].oe_n = pins_nxt[3].oe_n | ~`P3_PIN_MASK;
      pins_nxt[3].out  = pins_nxt[3].out & `P3_PIN_MASK;
   end

   // Answers back to the bus controller; ready idles high so a freed pin cannot stall
   always_comb begin
      resp_nxt.rdata    = {pins_in[2], pins_in[1]};
      resp_nxt.ready    = (micro & p3_on[`P3_RDY_BIT]) ? pins_in[3][`P3_RDY_BIT] : 1'b1;
      resp_nxt.hold_req = p4_on[`P4_HOLD_BIT] & ~pins_in[4][`P4_HOLD_BIT];
   end

   // Registered pads avoid glitches when a select changes mid-cycle
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int p = 0; p < `PORT_COUNT; p++) begin
            pins_r[p].out  <= 8'h00;
            pins_r[p].oe_n <= `PINS_IDLE;
         end
         resp_r <= '{rdata: 16'h0000, ready: 1'b1, hold_req: 1'b0};
      end else begin
         pins_r <= pins_nxt;
         resp_r <= resp_nxt;
      end
   end

   assign pins     = pins_r;
   assign bus_resp = resp_r;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   chk_width_pin_sel: assert property (
      ext && bus_width_pin |-> !wide_bus)
      else $error("width pin high did not give an 8-bit bus");

   chk_area_narrow: assert property (
      ext && !bus_width_pin && area_narrow[0] && !bus.chip_select_lines_n[1] |-> !wide_bus)
      else $error("narrowed area still wide");

   chk_single_dir: assert property (
      mode == MODE_SINGLE && $stable(dir[0]) |=> pins[0].oe_n == ~$past(dir[0]))
      else $error("port zero drive does not follow direction");

   chk_reset_input: assert property (
      $rose(reset_n) |-> pins[0].oe_n == 8'hff && pins[2].oe_n == 8'hff)
      else $error("pins driven right after reset");

   chk_hi_addr: assert property (
      ext && !p0_gpio_sel[7] |=> pins[0].out[7] == $past(bus.addr[23]) && !pins[0].oe_n[7])
      else $error("port zero bit 7 not carrying address 23");

   chk_data_low: assert property (
      ext && !muxed && bus.data_oe |=> pins[1].out == $past(bus.wdata[7:0]) && pins[1].oe_n == 8'h00)
      else $error("port one does not drive low data");

   chk_muxed_addr: assert property (
      muxed && bus.addr_phase |=> pins[1].out == $past(bus.addr[7:0]) && pins[1].oe_n == 8'h00)
      else $error("muxed address not presented on port one");

   chk_p2_release: assert property (
      ext && bus_width_pin ##1 $stable(dir[2]) && bus_width_pin |-> pins[2].oe_n == ~$past(dir[2]))
      else $error("port two not general I/O on 8-bit bus");

   chk_rd_strobe: assert property (
      expand |=> pins[3].out[1] == $past(bus.rd_strobe_n) && !pins[3].oe_n[1])
      else $error("read strobe not driven");

   chk_rdy_out: assert property (
      expand && p30_rdy_out_en |=> !pins[3].oe_n[0] && pins[3].out[0] == $past(bus.rdy_out))
      else $error("ready output not driven");

   chk_rdy_in: assert property (
      micro && !p30_gpio_sel |=> pins[3].oe_n[0] && bus_resp.ready == $past(pins_in[3][0]))
      else $error("ready input not taken");

   chk_bhw_free: assert property (
      ext && bus_width_pin && !dir[3][3] |=> pins[3].oe_n[3])
      else $error("high byte strobe still driven on 8-bit bus");

   chk_p4_expand: assert property (
      expand && !p4_func_en[0] && !dir[4][0] |=> pins[4].oe_n[0])
      else $error("port four bit 0 not I/O by default");

   chk_p4_micro: assert property (
      micro && !p4_gpio_sel[0] |=> pins[4].out[0] == $past(bus.ale) && !pins[4].oe_n[0])
      else $error("address latch enable not driven");

   chk_cs_extra: assert property (
      micro && p4_cs_en[2] |=> pins[4].out[7] == $past(bus.chip_select_lines_n[3]))
      else $error("chip select 3 not on port four bit 7");

   chk_low_addr: assert property (
      ext |=> pins[5].out == $past(bus.addr[7:0]) && pins[5].oe_n == 8'h00)
      else $error("port ten not carrying low address");

   chk_one_source: assert property (
      fsel[4][3] |=> pins[4].oe_n[3])
      else $error("hold request pin driven while an input");

   // Pads follow the inputs of the previous edge, so each check below looks one cycle back
   chk_high_data: assert property (
      ext && !bus_width_pin && bus.data_oe |=> pins[2].out == $past(bus.wdata[15:8]) && pins[2].oe_n == 8'h00)
      else $error("port two does not drive high data");

   chk_low_strobe: assert property (
      ext |=> pins[3].out[2] == $past(bus.low_byte_write_strobe_n) && !pins[3].oe_n[2])
      else $error("low byte write strobe not driven");

   chk_high_strobe: assert property (
      ext && !bus_width_pin |=> pins[3].out[3] == $past(bus.high_byte_write_strobe_n) && !pins[3].oe_n[3])
      else $error("high byte write strobe not driven on 16-bit bus");

   chk_ready_pin_io: assert property (
      expand && !p30_rdy_out_en |=> pins[3].oe_n[0] == !$past(dir[3][0]))
      else $error("port three bit 0 not general I/O in expansion");

   chk_ready_idle: assert property (
      micro && p30_gpio_sel |=> bus_resp.ready)
      else $error("ready not idle while its pin is general I/O");

   chk_hold_in: assert property (
      micro && !p4_gpio_sel[3] |=> bus_resp.hold_req == !$past(pins_in[4][3]))
      else $error("hold request not taken from port four bit 3");

   chk_cs0_micro: assert property (
      micro |=> pins[4].out[4] == $past(bus.chip_select_lines_n[0]) && !pins[4].oe_n[4])
      else $error("chip select 0 not on port four bit 4");

   chk_p4_revert: assert property (
      micro && p4_gpio_sel[0] |=> pins[4].oe_n[0] == !$past(dir[4][0]))
      else $error("port four bit 0 did not revert to I/O");

   chk_single_p4: assert property (
      mode == MODE_SINGLE |=> pins[4].oe_n == ~$past(dir[4]))
      else $error("port four drive does not follow direction");

   chk_p10_single: assert property (
      mode == MODE_SINGLE |=> pins[5].oe_n == ~$past(dir[5]))
      else $error("port ten drive does not follow direction");

   chk_p0_latch: assert property (
      ext && p0_gpio_sel[7] |=> pins[0].out[7] == $past(dout[0][7]) && pins[0].oe_n[7] == !$past(dir[0][7]))
      else $error("port zero bit 7 not returned to I/O");

   chk_p4_cs_expand: assert property (
      expand && p4_func_en[7] |=> pins[4].out[7] == $past(bus.chip_select_lines_n[3]) && !pins[4].oe_n[7])
      else $error("chip select 3 not switched onto port four in expansion");

endmodule
`default_nettype wire

// *** inc/external_bus_pin_mux_params.svh ***
// Bit positions, reset values and pin constants for the external bus pin multiplexer
`ifndef EXTERNAL_BUS_PIN_MUX_PARAMS_SVH
`define EXTERNAL_BUS_PIN_MUX_PARAMS_SVH

`define DIR_RESET       8'h00
`define DOUT_RESET      8'h00
`define PINS_IDLE       8'hff
`define ADDR_HI_LSB     16
`define P3_RDY_BIT      0
`define P3_RD_BIT       1
`define P3_BLW_BIT      2
`define P3_BHW_BIT      3
`define P3_PIN_MASK     8'h0f
`define P4_ALE_BIT      0
`define P4_CLK_BIT      1
`define P4_HOLD_ACKNOWLEDGE_BIT     2
`define P4_HOLD_BIT     3
`define P4_CS0_BIT      4
`define P4_FUNC_OE_N    8'h08
`define PORT_COUNT      6
`define PORT_TEN_IDX    5

`endif

// *** inc/pin_mux_pkg.sv ***
// Types shared by the external bus pin multiplexer
package pin_mux_pkg;

   typedef enum logic [1:0] {
      MODE_SINGLE,
      MODE_EXPAND,
      MODE_MICRO
   } mode_e;

   // Drive of one 8-pin port; oe_n low means the pin is driven
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
   } port_pins_s;

   // Bus controller requests towards the pins
   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] wdata;
      logic        data_oe;
      logic        addr_phase;
      logic        rd_strobe_n;
      logic        low_byte_write_strobe_n;
      logic        high_byte_write_strobe_n;
      logic        ale;
      logic        bus_clk;
      logic        hold_acknowledge_n;
      logic [3:0]  chip_select_lines_n;
      logic        rdy_out;
   } bus_ctrl_s;

   // Pin-side answers to the bus controller
   typedef struct packed {
      logic [15:0] rdata;
      logic        ready;
      logic        hold_req;
   } bus_resp_s;

endpackage

// *** verilog/gpio_port.sv ***
// Direction and output latch of one general I/O port
`timescale 1ns/10ps
`default_nettype none
`include "external_bus_pin_mux_params.svh"

module gpio_port #(
   parameter int W = 8
) (
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   input  wire logic         dir_we,
   input  wire logic         data_we,
   input  wire logic [W-1:0] wr_data,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] dir,
   output logic      [W-1:0] dout,
   output logic      [W-1:0] rd_data
);

   logic [W-1:0] dir_r;
   logic [W-1:0] dir_nxt;
   logic [W-1:0] dout_r;
   logic [W-1:0] dout_nxt;
   logic [W-1:0] rd_r;
   logic [W-1:0] rd_nxt;

   // Output pins read back the latch, input pins the pad level
   always_comb begin
      dir_nxt  = dir_we ? wr_data : dir_r;
      dout_nxt = data_we ? wr_data : dout_r;
      rd_nxt   = (dir_r & dout_r) | (~dir_r & pin_in);
   end

   // Direction clears so every pin wakes up as an input
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dir_r  <= W'(`DIR_RESET);
         dout_r <= W'(`DOUT_RESET);
         rd_r   <= '0;
      end else begin
         dir_r  <= dir_nxt;
         dout_r <= dout_nxt;
         rd_r   <= rd_nxt;
      end
   end

   assign dir     = dir_r;
   assign dout    = dout_r;
   assign rd_data = rd_r;

endmodule
`default_nettype wire

// *** sim/ext_bus_partner.sv ***
// Behavioural model of the external memory and pads facing the pin multiplexer
`timescale 1ns/10ps
`default_nettype none
module ext_bus_partner
   import pin_mux_pkg::*;
(
   input  wire pin_mux_pkg::port_pins_s [5:0] pins,
   input  wire logic [15:0]                   mem_rdata,
   input  wire logic                          rdy_level,
   input  wire logic                          hold_n_level,
   input  wire logic [7:0]                    idle_in,
   output logic      [5:0][7:0]               pins_in
);
   // A pad shows the device drive where enabled, otherwise what the far side puts there
   always_comb begin
      for (int p = 0; p < 6; p++) begin
         for (int b = 0; b < 8; b++) begin
            pins_in[p][b] = pins[p].oe_n[b] ? idle_in[b] : pins[p].out[b];
         end
      end
      if (pins[1].oe_n == 8'hff) pins_in[1] = mem_rdata[7:0];
      if (pins[2].oe_n == 8'hff) pins_in[2] = mem_rdata[15:8];
      if (pins[3].oe_n[0]) pins_in[3][0] = rdy_level;
      if (pins[4].oe_n[3]) pins_in[4][3] = hold_n_level;
   end
endmodule
`default_nettype wire

// *** sim/external_bus_pin_mux_tb.sv ***
// Self-checking testbench for the external bus pin multiplexer
`timescale 1ns/10ps
`default_nettype none
module external_bus_pin_mux_tb;
   import pin_mux_pkg::*;
   logic                 core_clk, reset_n, proc_mode_pin, expand_sel, bus_width_pin;
   logic                 p1_mux_en, p30_rdy_out_en, p30_gpio_sel, wide_bus, rdy_level, hold_n_level;
   logic [2:0]           area_narrow, p4_cs_en;
   logic [7:0]           p0_gpio_sel, p4_func_en, wr_data;
   logic [3:0]           p4_gpio_sel;
   logic [5:0]           dir_we, data_we;
   logic [15:0]          mem_rdata;
   logic [5:0][7:0]      pins_in, port_rd;
   bus_ctrl_s            bus;
   bus_resp_s            bus_resp;
   port_pins_s [5:0]     pins;
   int                   bad_count, n_compared;

   external_bus_pin_mux external_bus_pin_mux_i (
      .core_clk(core_clk), .reset_n(reset_n), .proc_mode_pin(proc_mode_pin), .expand_sel(expand_sel),
      .bus_width_pin(bus_width_pin), .area_narrow(area_narrow), .p0_gpio_sel(p0_gpio_sel),
      .p1_mux_en(p1_mux_en), .p30_rdy_out_en(p30_rdy_out_en), .p30_gpio_sel(p30_gpio_sel),
      .p4_func_en(p4_func_en), .p4_gpio_sel(p4_gpio_sel), .p4_cs_en(p4_cs_en), .dir_we(dir_we),
      .data_we(data_we), .wr_data(wr_data), .bus(bus), .pins_in(pins_in), .pins(pins),
      .bus_resp(bus_resp), .port_rd(port_rd), .wide_bus(wide_bus));

   ext_bus_partner ext_bus_partner_i (
      .pins(pins), .mem_rdata(mem_rdata), .rdy_level(rdy_level), .hold_n_level(hold_n_level),
      .idle_in(8'h3c), .pins_in(pins_in));

   // 125 MHz core clock
   always #4 core_clk = ~core_clk;

   // Compare one value and count the outcome
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Two edges carry an input change through the registered pads; look at the falling edge
   task automatic settle;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   // One-cycle write pulse to the direction or output latch of a port
   task automatic wr(input int p, input logic is_dir, input logic [7:0] v);
      @(posedge core_clk);
      if (is_dir) dir_we[p] <= 1'b1;
      else data_we[p] <= 1'b1;
      wr_data <= v;
      @(posedge core_clk);
      dir_we  <= 6'h00;
      data_we <= 6'h00;
   endtask

   task automatic t_single;
      @(posedge core_clk);
      proc_mode_pin <= 1'b0;
      wr(0, 1'b1, 8'h0f);
      wr(0, 1'b0, 8'ha5);
      settle;
      chk("p0 oe_n", 16'h00f0, {8'h00, pins[0].oe_n});
      chk("p0 out", 16'h0005, {8'h00, pins[0].out & 8'h0f});
      chk("p0 read", 16'h0035, {8'h00, port_rd[0]});
      chk("p2 oe_n", 16'h00ff, {8'h00, pins[2].oe_n});
   endtask

   task automatic t_expand16;
      @(posedge core_clk);
      expand_sel  <= 1'b1;
      p0_gpio_sel <= 8'h80;
      bus.addr    <= 24'h123456;
      bus.wdata   <= 16'hbeef;
      bus.data_oe <= 1'b1;
      bus.low_byte_write_strobe_n  <= 1'b0;
      bus.high_byte_write_strobe_n <= 1'b0;
      settle;
      chk("p0 oe_n", 16'h0080, {8'h00, pins[0].oe_n});
      chk("p0 addr", 16'h0012, {8'h00, pins[0].out & 8'h7f});
      chk("p10 addr", 16'h0056, {8'h00, pins[5].out});
      chk("data out", 16'hbeef, {pins[2].out, pins[1].out});
      chk("wide", 16'h0001, {15'h0000, wide_bus});
      chk("p3 oe_n", 16'h0001, {8'h00, pins[3].oe_n & 8'h0f});
      chk("p3 out", 16'h0002, {8'h00, pins[3].out & 8'h0e});
      @(posedge core_clk);
      bus.data_oe <= 1'b0;
      mem_rdata   <= 16'h1357;
      settle;
      chk("p1 oe_n", 16'h00ff, {8'h00, pins[1].oe_n});
      chk("rdata", 16'h1357, bus_resp.rdata);
   endtask

   task automatic t_byte;
      @(posedge core_clk);
      bus_width_pin  <= 1'b1;
      p1_mux_en      <= 1'b1;
      bus.addr_phase <= 1'b1;
      bus.data_oe    <= 1'b1;
      settle;
      chk("wide", 16'h0000, {15'h0000, wide_bus});
      chk("p2 oe_n", 16'h00ff, {8'h00, pins[2].oe_n});
      chk("p3 oe_n3", 16'h0001, {15'h0000, pins[3].oe_n[3]});
      chk("p1 addr", 16'h0056, {8'h00, pins[1].out});
      @(posedge core_clk);
      bus.addr_phase <= 1'b0;
      settle;
      chk("p1 data", 16'h00ef, {8'h00, pins[1].out});
      @(posedge core_clk);
      bus_width_pin <= 1'b0;
      p1_mux_en     <= 1'b0;
      area_narrow   <= 3'b001;
      bus.chip_select_lines_n <= 4'b1101;
      settle;
      chk("narrow", 16'h0000, {15'h0000, wide_bus});
      @(posedge core_clk);
      bus.chip_select_lines_n <= 4'b0111;
      settle;
      chk("not narrow", 16'h0001, {15'h0000, wide_bus});
   endtask

   task automatic t_expand_p4;
      @(posedge core_clk);
      p4_func_en     <= 8'hff;
      p30_rdy_out_en <= 1'b1;
      hold_n_level   <= 1'b0;
      settle;
      chk("p4 oe_n", 16'h0008, {8'h00, pins[4].oe_n});
      chk("p4 out", 16'h0074, {8'h00, pins[4].out & 8'hf7});
      chk("hold", 16'h0001, {15'h0000, bus_resp.hold_req});
      chk("rdy out", 16'h0000, {14'h0000, pins[3].oe_n[0], pins[3].out[0]});
   endtask

   task automatic t_micro;
      @(posedge core_clk);
      proc_mode_pin  <= 1'b1;
      p4_func_en     <= 8'h00;
      p30_rdy_out_en <= 1'b0;
      settle;
      chk("p4 oe_n", 16'h00e8, {8'h00, pins[4].oe_n});
      chk("ready", 16'h0000, {15'h0000, bus_resp.ready});
      chk("hold", 16'h0001, {15'h0000, bus_resp.hold_req});
      @(posedge core_clk);
      p30_gpio_sel <= 1'b1;
      p4_gpio_sel  <= 4'hf;
      p4_cs_en     <= 3'h7;
      settle;
      chk("ready", 16'h0001, {15'h0000, bus_resp.ready});
      chk("p4 oe_n", 16'h000f, {8'h00, pins[4].oe_n});
      chk("p4 cs", 16'h0060, {8'h00, pins[4].out & 8'he0});
   endtask

   task automatic final_report;
      $display("Compared %0d, errors %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Main sequence: reset, then each scenario in turn
   initial begin
      core_clk = 1'b0;
      reset_n = 1'b0;
      {proc_mode_pin, expand_sel, bus_width_pin, p1_mux_en, p30_rdy_out_en, p30_gpio_sel} = 6'h00;
      {area_narrow, p4_cs_en, p4_gpio_sel} = 10'h000;
      {p0_gpio_sel, p4_func_en, wr_data} = 24'h000000;
      {dir_we, data_we} = 12'h000;
      mem_rdata = 16'h0000;
      rdy_level = 1'b0;
      hold_n_level = 1'b1;
      bus = '0;
      bus.rd_strobe_n = 1'b1;
      bus.hold_acknowledge_n = 1'b1;
      bad_count = 0;
      n_compared = 0;
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      chk("reset oe_n", 16'h00ff, {8'h00, pins[0].oe_n});
      chk("reset ready", 16'h0001, {15'h0000, bus_resp.ready});
      @(posedge core_clk);
      reset_n <= 1'b1;
      t_single;
      t_expand16;
      t_byte;
      t_expand_p4;
      t_micro;
      final_report;
   end

   // Whole run needs well under 200 cycles; a stall past 2500 cycles is a hang
   initial begin
      #20000;
      bad_count++;
      final_report;
   end
endmodule
`default_nettype wire
